// ===== src/codec_slot_pkg.sv
// Constants shared by the serial codec slot channel block
package codec_slot_pkg;

    // Register byte offsets (word aligned)
    localparam logic [7:0] OFF_STATUS       = 8'h0C;
    localparam logic [7:0] OFF_CTRL         = 8'h08;
    localparam logic [7:0] OFF_RATE         = 8'h10;
    localparam logic [7:0] OFF_CMD_ADDR     = 8'h20;
    localparam logic [7:0] OFF_CMD_DATA     = 8'h24;
    localparam logic [7:0] OFF_FRONT_LEFT   = 8'h28;
    localparam logic [7:0] OFF_FRONT_RIGHT  = 8'h2C;
    localparam logic [7:0] OFF_LINE_ONE     = 8'h30;
    localparam logic [7:0] OFF_CENTER       = 8'h34;
    localparam logic [7:0] OFF_LEFT_SURR    = 8'h38;
    localparam logic [7:0] OFF_RIGHT_SURR   = 8'h3C;
    localparam logic [7:0] OFF_IRQ_MASK     = 8'h70;

    // Field positions
    localparam int STAT_DONE_BIT    = 0;
    localparam int STAT_OVR_BIT     = 1;
    localparam int CTRL_RECEIVE_ENABLE_BIT    = 0;
    localparam int RATE_W           = 3;
    localparam int CMD_RW_BIT       = 19;
    localparam int CMD_ADDR_LSB     = 12;
    localparam int CMD_ADDR_W       = 7;
    localparam int CMD_DATA_LSB     = 4;
    localparam int CMD_DATA_W       = 16;
    localparam int SAMPLE_W         = 20;

    // Rate codes
    localparam logic [2:0] RATE_8K    = 3'h0;
    localparam logic [2:0] RATE_9K6   = 3'h1;
    localparam logic [2:0] RATE_12K   = 3'h2;
    localparam logic [2:0] RATE_16K   = 3'h3;
    localparam logic [2:0] RATE_24K   = 3'h4;
    localparam logic [2:0] RATE_48K   = 3'h5;

    // FIFO shape and reset values
    localparam int FIFO_DEPTH       = 4;
    localparam int PTR_W            = 2;
    localparam int BLOCK_LEVEL      = 2;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // Transmit/receive slot indices
    localparam int SLOT_CMD_DATA    = 0;
    localparam int SLOT_FL          = 1;
    localparam int SLOT_FR          = 2;
    localparam int SLOT_L1          = 3;
    localparam int SLOT_CM          = 4;
    localparam int SLOT_LS          = 5;
    localparam int SLOT_RS          = 6;
    localparam int N_TX             = 7;
    localparam int N_RX             = 5;

endpackage : codec_slot_pkg

// ===== src/codec_slot_channels.sv
// Register side of the serial codec slot channels with per-slot FIFOs
`timescale 1ns/1ns

// Notes on behaviour
// - Receive overrun sets status bit 1; writing one clears it.
// - Receive block filled sets status bit 0; writing one clears it.
// - Three-bit rate code selects 8 to 48 kHz in slave mode three.
// - Rate and channel registers clear on reset, hold through standby.
// - Command address holds read flag bit 19 and address bits 18..12.
// - Command address bits 31..20 and 11..0 are reserved.
// - Command data write queues bits 19..4 into command transmit FIFO.
// - Command data read pops oldest command receive FIFO entry.
// - Command data bits 31..20 and 3..0 are reserved.
// - Front-left write queues 20-bit playback sample.
// - Front-left read returns oldest record sample.
// - Front-right queues writes, reads oldest receive entry, top bits reserved.
// - Line-one write queues output sample, read returns oldest input.
// - Center write queues playback, read returns oldest microphone sample.
// - Left-surround is write-only, each write queues a sample.
// - Right-surround is write-only, each write queues a sample.
// - Receive enable gates receive-done interrupt and receive path.
module codec_slot_channels (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Standby request, registers keep contents
    input  wire logic        standby,
    // Transmit side toward the serial framer, one slot per index
    input  wire logic [6:0]  tx_pop,
    output logic      [6:0]  tx_valid,
    output logic      [19:0] tx_data [7],
    // Receive side from the serial framer
    input  wire logic [4:0]  rx_push,
    input  wire logic [19:0] rx_data [5],
    // Command address toward framer
    output logic             cmd_read_flag,
    output logic      [6:0]  codec_reg_address,
    input  wire logic        status_addr_load,
    input  wire logic [6:0]  status_addr_in,
    // Configuration outputs
    output logic      [2:0]  rate_code,
    output logic             receive_enable,
    // Interrupt
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage

    logic [19:0] tx_mem   [7][4];
    logic [2:0]  tx_cnt_reg [7];
    logic [1:0]  tx_rp_reg  [7];
    logic [19:0] rx_mem   [5][4];
    logic [2:0]  rx_cnt_reg [5];
    logic [1:0]  rx_rp_reg  [5];
    logic [2:0]  rate_reg;
    logic [7:0]  cmd_addr_reg;
    logic        receive_enable_reg;
    logic [1:0]  status_reg;
    logic [1:0]  mask_reg;
    logic [6:0]  tx_wr;
    logic [4:0]  rx_rd;
    logic [4:0]  rx_ok;
    logic [1:0]  stat_set;
    logic        std_s1_reg;
    logic        std_s2_reg;
    logic [6:0]  tx_do_w;
    logic [6:0]  tx_do_r;
    logic [4:0]  rx_do_w;
    logic [4:0]  rx_do_r;

    // Write offset of a slot's next free entry
    function automatic logic [1:0] wr_ptr(input logic [1:0] rp, input logic [2:0] cnt);
        wr_ptr = rp + cnt[1:0];
    endfunction : wr_ptr

    // A queue is full once its count reaches the depth
    function automatic logic fifo_full(input logic [2:0] cnt);
        fifo_full = (cnt == 3'(codec_slot_pkg::FIFO_DEPTH));
    endfunction : fifo_full

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    // Queue strobes, a transmit write per channel register and a receive read for five of them
    always_comb begin
        tx_wr = 7'h00;
        rx_rd = 5'h00;
        if (reg_wr) begin
            case (reg_addr)
                codec_slot_pkg::OFF_CMD_DATA:    tx_wr[0] = 1'b1;
                codec_slot_pkg::OFF_FRONT_LEFT:  tx_wr[1] = 1'b1;
                codec_slot_pkg::OFF_FRONT_RIGHT: tx_wr[2] = 1'b1;
                codec_slot_pkg::OFF_LINE_ONE:    tx_wr[3] = 1'b1;
                codec_slot_pkg::OFF_CENTER:      tx_wr[4] = 1'b1;
                codec_slot_pkg::OFF_LEFT_SURR:   tx_wr[5] = 1'b1;
                codec_slot_pkg::OFF_RIGHT_SURR:  tx_wr[6] = 1'b1;
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                codec_slot_pkg::OFF_CMD_DATA:    rx_rd[0] = 1'b1;
                codec_slot_pkg::OFF_FRONT_LEFT:  rx_rd[1] = 1'b1;
                codec_slot_pkg::OFF_FRONT_RIGHT: rx_rd[2] = 1'b1;
                codec_slot_pkg::OFF_LINE_ONE:    rx_rd[3] = 1'b1;
                codec_slot_pkg::OFF_CENTER:      rx_rd[4] = 1'b1;
                default: ;
            endcase
        end
    end

    // Standby is a pin level, synchronised; it freezes nothing and resets nothing
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            std_s1_reg <= 1'b0;
            std_s2_reg <= 1'b0;
        end else begin
            std_s1_reg <= standby;
            std_s2_reg <= std_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    // Rate code; only the three defined bits are stored, the rest read zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rate_reg <= 3'h0;
        end else if (reg_wr && reg_addr == codec_slot_pkg::OFF_RATE) begin
            rate_reg <= reg_wdata[2:0];
        end
    end

    // Receive enable; clearing it also stops new pushes into the record queues
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            receive_enable_reg <= 1'b0;
        end else if (reg_wr && reg_addr == codec_slot_pkg::OFF_CTRL) begin
            receive_enable_reg <= reg_wdata[codec_slot_pkg::CTRL_RECEIVE_ENABLE_BIT];
        end
    end

    // Interrupt mask; a one silences the matching status bit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_reg <= 2'h0;
        end else if (reg_wr && reg_addr == codec_slot_pkg::OFF_IRQ_MASK) begin
            mask_reg <= reg_wdata[1:0];
        end
    end

    // Command address; the framer may load a returned status address
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_addr_reg <= 8'h00;
        end else if (reg_wr && reg_addr == codec_slot_pkg::OFF_CMD_ADDR) begin
            cmd_addr_reg <= reg_wdata[19:12];
        end else if (status_addr_load) begin
            cmd_addr_reg <= {cmd_addr_reg[7], status_addr_in};
        end
    end

    assign rate_code         = rate_reg;
    assign receive_enable    = receive_enable_reg;
    assign cmd_read_flag     = cmd_addr_reg[7];
    assign codec_reg_address = cmd_addr_reg[6:0];

    ////////////////////////////////////////////////////////////////////////////
    // Transmit FIFOs; a write to a full queue is dropped

    // Accepted writes and pops; the framer may pop an empty queue harmlessly
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            tx_do_w[i] = tx_wr[i] && !fifo_full(tx_cnt_reg[i]);
            tx_do_r[i] = tx_pop[i] && (tx_cnt_reg[i] != 3'h0);
        end
    end

    // Sample storage; the command slot keeps only its 16 data bits
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 7; i++) begin
                for (int j = 0; j < 4; j++)
                    tx_mem[i][j] <= 20'h00000;
            end
        end else begin
            for (int i = 0; i < 7; i++) begin
                if (tx_do_w[i] && i == codec_slot_pkg::SLOT_CMD_DATA)
                    tx_mem[i][wr_ptr(tx_rp_reg[i], tx_cnt_reg[i])] <=
                        {4'h0, reg_wdata[19:4]};
                else if (tx_do_w[i])
                    tx_mem[i][wr_ptr(tx_rp_reg[i], tx_cnt_reg[i])] <=
                        reg_wdata[19:0];
            end
        end
    end

    // Read pointers wrap in two bits, which matches the depth of four
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 7; i++)
                tx_rp_reg[i] <= 2'h0;
        end else begin
            for (int i = 0; i < 7; i++) begin
                if (tx_do_r[i])
                    tx_rp_reg[i] <= tx_rp_reg[i] + 2'h1;
            end
        end
    end

    // Fill counts; a write and a pop in one cycle cancel out
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 7; i++)
                tx_cnt_reg[i] <= 3'h0;
        end else begin
            for (int i = 0; i < 7; i++)
                tx_cnt_reg[i] <= tx_cnt_reg[i] + {2'h0, tx_do_w[i]} - {2'h0, tx_do_r[i]};
        end
    end

    always_comb begin
        for (int i = 0; i < 7; i++) begin
            tx_valid[i] = (tx_cnt_reg[i] != 3'h0);
            tx_data[i]  = tx_mem[i][tx_rp_reg[i]];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive FIFOs; gated by receive enable, overrun on push into full

    // Accepted pushes and pops; reading an empty queue shows a stale entry
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            rx_ok[i]   = rx_push[i] && receive_enable_reg;
            rx_do_w[i] = rx_ok[i] && !fifo_full(rx_cnt_reg[i]);
            rx_do_r[i] = rx_rd[i] && (rx_cnt_reg[i] != 3'h0);
        end
    end

    // Record sample storage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 5; i++) begin
                for (int j = 0; j < 4; j++)
                    rx_mem[i][j] <= 20'h00000;
            end
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (rx_do_w[i])
                    rx_mem[i][wr_ptr(rx_rp_reg[i], rx_cnt_reg[i])] <= rx_data[i];
            end
        end
    end

    // Read pointers advance on each register read of a non-empty queue
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 5; i++)
                rx_rp_reg[i] <= 2'h0;
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (rx_do_r[i])
                    rx_rp_reg[i] <= rx_rp_reg[i] + 2'h1;
            end
        end
    end

    // Fill counts; a push and a read in one cycle cancel out
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 5; i++)
                rx_cnt_reg[i] <= 3'h0;
        end else begin
            for (int i = 0; i < 5; i++)
                rx_cnt_reg[i] <= rx_cnt_reg[i] + {2'h0, rx_do_w[i]} - {2'h0, rx_do_r[i]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags and interrupt

    // Block done when a push brings any queue to the block level
    always_comb begin
        stat_set = 2'h0;
        for (int i = 0; i < 5; i++) begin
            if (rx_ok[i] && fifo_full(rx_cnt_reg[i]))
                stat_set[codec_slot_pkg::STAT_OVR_BIT] = 1'b1;
            if (rx_ok[i] && rx_cnt_reg[i] == 3'(codec_slot_pkg::BLOCK_LEVEL - 1))
                stat_set[codec_slot_pkg::STAT_DONE_BIT] = 1'b1;
        end
    end

    // Write-one-to-clear; a set in the same cycle wins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_reg <= 2'h0;
        end else begin
            for (int b = 0; b < 2; b++) begin
                if (stat_set[b])
                    status_reg[b] <= 1'b1;
                else if (reg_wr && reg_addr == codec_slot_pkg::OFF_STATUS && reg_wdata[b])
                    status_reg[b] <= 1'b0;
            end
        end
    end

    // A set mask bit silences its flag; done also needs receive enable
    assign irq = (status_reg[1] & ~mask_reg[1])
               | (status_reg[0] & ~mask_reg[0] & receive_enable_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= codec_slot_pkg::RESET_WORD;
        end else if (reg_rd) begin
            case (reg_addr)
                codec_slot_pkg::OFF_STATUS:      reg_rdata <= {30'h0, status_reg};
                codec_slot_pkg::OFF_CTRL:        reg_rdata <= {31'h0, receive_enable_reg};
                codec_slot_pkg::OFF_IRQ_MASK:    reg_rdata <= {30'h0, mask_reg};
                codec_slot_pkg::OFF_RATE:        reg_rdata <= {29'h0, rate_reg};
                codec_slot_pkg::OFF_CMD_ADDR:    reg_rdata <= {12'h0, cmd_addr_reg, 12'h0};
                codec_slot_pkg::OFF_CMD_DATA:
                    reg_rdata <= {12'h0, rx_mem[0][rx_rp_reg[0]][15:0], 4'h0};
                codec_slot_pkg::OFF_FRONT_LEFT:  reg_rdata <= {12'h0, rx_mem[1][rx_rp_reg[1]]};
                codec_slot_pkg::OFF_FRONT_RIGHT: reg_rdata <= {12'h0, rx_mem[2][rx_rp_reg[2]]};
                codec_slot_pkg::OFF_LINE_ONE:    reg_rdata <= {12'h0, rx_mem[3][rx_rp_reg[3]]};
                codec_slot_pkg::OFF_CENTER:      reg_rdata <= {12'h0, rx_mem[4][rx_rp_reg[4]]};
                default:                         reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule : codec_slot_channels

// ===== tb/codec_slot_assertions.sv
// Checker for the codec slot channel register port and slot outputs
`timescale 1ns/1ns
module codec_slot_assertions (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // Register port
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Slot side and configuration
    input wire logic        standby,
    input wire logic [6:0]  tx_valid,
    input wire logic [19:0] tx_data [7],
    input wire logic        status_addr_load,
    input wire logic        cmd_read_flag,
    input wire logic [6:0]  codec_reg_address,
    input wire logic [2:0]  rate_code
);
    logic [31:0] wd_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////
    // Write data delayed one cycle, so next-cycle checks compare against slices of the written value
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) wd_q <= 32'h0;
        else wd_q <= reg_wdata;
    end
    ////////////////////////
    // Reads: data only in the cycle after the strobe, reserved bits zero
    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero outside read answer");
    AST_RATE_RSVD: assert property (
        reg_rd && reg_addr == codec_slot_pkg::OFF_RATE |=> reg_rdata[31:3] == 29'h0)
        else $error("rate register reserved bits set");
    AST_CADDR_RSVD: assert property (
        reg_rd && reg_addr == codec_slot_pkg::OFF_CMD_ADDR
        |=> {reg_rdata[31:20], reg_rdata[11:0]} == 24'h0)
        else $error("command address reserved bits set");
    AST_CDATA_RSVD: assert property (
        reg_rd && reg_addr == codec_slot_pkg::OFF_CMD_DATA
        |=> {reg_rdata[31:20], reg_rdata[3:0]} == 16'h0)
        else $error("command data reserved bits set");
    AST_SURR_WO: assert property (reg_rd && reg_addr[7:3] == 5'h07 |=> reg_rdata == 32'h0)
        else $error("surround channel read not zero");
    // Writes reach the outputs on the next cycle
    AST_RATE_WR: assert property (
        reg_wr && reg_addr == codec_slot_pkg::OFF_RATE |=> rate_code == wd_q[2:0])
        else $error("rate code not taken from write");
    AST_CADDR_WR: assert property (
        reg_wr && reg_addr == codec_slot_pkg::OFF_CMD_ADDR && !status_addr_load
        |=> {cmd_read_flag, codec_reg_address} == wd_q[19:12])
        else $error("command address fields wrong");
    AST_FL_QUEUE: assert property (
        reg_wr && reg_addr == codec_slot_pkg::OFF_FRONT_LEFT && !tx_valid[1]
        |=> tx_valid[1] && tx_data[1] == wd_q[19:0])
        else $error("front left sample not queued");
    AST_CMD_QUEUE: assert property (
        reg_wr && reg_addr == codec_slot_pkg::OFF_CMD_DATA && !tx_valid[0]
        |=> tx_valid[0] && tx_data[0][15:0] == wd_q[19:4])
        else $error("command data not queued");
    AST_STANDBY_HOLD: assert property (
        standby && !reg_wr && !status_addr_load
        |=> $stable(rate_code) && $stable(codec_reg_address))
        else $error("configuration changed in standby");
endmodule : codec_slot_assertions
bind codec_slot_channels codec_slot_assertions chk_u (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .standby(standby), .tx_valid(tx_valid), .tx_data(tx_data),
    .status_addr_load(status_addr_load), .cmd_read_flag(cmd_read_flag),
    .codec_reg_address(codec_reg_address), .rate_code(rate_code));

// ===== tb/framer_model.sv
// Behavioural serial framer that pops and pushes the slot FIFOs
`timescale 1ns/1ns
module framer_model (
    // Clock
    input  wire logic        clk,
    // Slot pops and pushes
    output logic      [6:0]  tx_pop,
    output logic      [4:0]  rx_push,
    output logic      [19:0] rx_data [5],
    // Returned status address
    output logic             status_addr_load,
    output logic      [6:0]  status_addr_in
);
    // Idle at time zero
    initial begin
        tx_pop = 7'h00;
        rx_push = 5'h00;
        status_addr_load = 1'b0;
        status_addr_in = 7'h00;
        foreach (rx_data[i]) rx_data[i] = 20'h00000;
    end
    // One-cycle pop of one slot
    task automatic pop(input int s);
        @(posedge clk);
        tx_pop[s] <= 1'b1;
        @(posedge clk);
        tx_pop[s] <= 1'b0;
    endtask : pop
    // Data is inverted after the push so a late sampler cannot see it
    task automatic push(input int s, input logic [19:0] d);
        @(posedge clk);
        rx_push[s] <= 1'b1;
        rx_data[s] <= d;
        @(posedge clk);
        rx_push[s] <= 1'b0;
        rx_data[s] <= ~d;
    endtask : push
    // Status address returned by the codec
    task automatic load_addr(input logic [6:0] a);
        @(posedge clk);
        status_addr_load <= 1'b1;
        status_addr_in <= a;
        @(posedge clk);
        status_addr_load <= 1'b0;
        status_addr_in <= ~a;
    endtask : load_addr
endmodule : framer_model

// ===== tb/testbench.sv
// Self-checking bench for the codec slot channels
`timescale 1ns/1ns
module testbench;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v, exp_q [$];
    logic        clk, reset_n, reg_wr, reg_rd, standby, rd_seen;
    logic [6:0]  tx_pop, tx_valid, codec_reg_address, status_addr_in;
    logic [19:0] tx_data [7];
    logic [19:0] rx_data [5];
    logic [19:0] w [5];
    logic [4:0]  rx_push;
    logic [2:0]  rate_code;
    logic        cmd_read_flag, status_addr_load, receive_enable, irq;
    int          fail_count, check_count, cycles;
    localparam logic [7:0] OFFS [7] = '{8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C};
    codec_slot_channels dut_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .standby(standby), .tx_pop(tx_pop), .tx_valid(tx_valid), .tx_data(tx_data),
        .rx_push(rx_push), .rx_data(rx_data), .cmd_read_flag(cmd_read_flag),
        .codec_reg_address(codec_reg_address), .status_addr_load(status_addr_load),
        .status_addr_in(status_addr_in), .rate_code(rate_code),
        .receive_enable(receive_enable), .irq(irq));
    framer_model partner_u (.clk(clk), .tx_pop(tx_pop), .rx_push(rx_push),
        .rx_data(rx_data), .status_addr_load(status_addr_load),
        .status_addr_in(status_addr_in));
    ////////////////////////
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Expected read data is queued; the monitor below compares it
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : rd
    // Command slot carries only 16 bits, so its top nibble is masked
    task automatic txchk(input int s, input logic [19:0] e);
        @(negedge clk);
        chk({12'h0, e}, {12'h0, tx_data[s] & (s == 0 ? 20'h0FFFF : 20'hFFFFF)});
        partner_u.pop(s);
    endtask : txchk
    ////////////////////////
    // Clock and hang guard; the ceiling leaves ample room for the sequence
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            close_out();
        end
    end
    // Read answer appears only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_seen === 1'b1) chk(exp_q.pop_front(), reg_rdata);
        rd_seen <= reg_rd;
    end
    ////////////////////////
    initial begin
        {reset_n, reg_wr, reg_rd, standby, rd_seen, reg_addr, reg_wdata} = '0;
        {fail_count, check_count, cycles} = '0;
        v = $urandom(32'h8217FF43);
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 5; i++) rd(OFFS[i], 32'h0);
        rd(codec_slot_pkg::OFF_RATE, 32'h0);
        for (int i = 0; i < 6; i++) begin
            wr(codec_slot_pkg::OFF_RATE, ($urandom & 32'hFFFFFFF8) | i);
            rd(codec_slot_pkg::OFF_RATE, i);
        end
        standby <= 1'b1;
        v = $urandom;
        wr(codec_slot_pkg::OFF_CMD_ADDR, v);
        rd(codec_slot_pkg::OFF_CMD_ADDR, v & 32'h000FF000);
        rd(codec_slot_pkg::OFF_RATE, 32'h5);
        chk({24'h0, cmd_read_flag, codec_reg_address}, {24'h0, v[19:12]});
        standby <= 1'b0;
        partner_u.load_addr(7'h2A);
        rd(codec_slot_pkg::OFF_CMD_ADDR, (v & 32'h00080000) | 32'h0002A000);
        // One sample per playback slot, then a front-left fill past full
        for (int s = 0; s < 7; s++) begin
            v = $urandom;
            wr(OFFS[s], v);
            txchk(s, s == 0 ? {4'h0, v[19:4]} : v[19:0]);
        end
        for (int i = 0; i < 5; i++) begin
            w[i] = $urandom;
            wr(codec_slot_pkg::OFF_FRONT_LEFT, {12'h0, w[i]});
        end
        for (int i = 0; i < 4; i++) txchk(1, w[i]);
        @(negedge clk);
        chk({31'h0, tx_valid[1]}, 32'h0);
        // Record side with receive enabled
        wr(codec_slot_pkg::OFF_CTRL, 32'h1);
        @(negedge clk);
        chk({31'h0, receive_enable}, 32'h1);
        for (int s = 0; s < 5; s++) begin
            v = $urandom;
            partner_u.push(s, v[19:0]);
            rd(OFFS[s], s == 0 ? {12'h0, v[15:0], 4'h0} : {12'h0, v[19:0]});
        end
        for (int i = 0; i < 2; i++) partner_u.push(1, w[i]);
        @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(codec_slot_pkg::OFF_IRQ_MASK, 32'h3);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(codec_slot_pkg::OFF_IRQ_MASK, 32'h0);
        rd(codec_slot_pkg::OFF_STATUS, 32'h1);
        wr(codec_slot_pkg::OFF_STATUS, 32'h1);
        rd(codec_slot_pkg::OFF_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        for (int i = 0; i < 2; i++) rd(codec_slot_pkg::OFF_FRONT_LEFT, {12'h0, w[i]});
        // Overrun: five pushes into a four-entry receive FIFO
        for (int i = 0; i < 5; i++) partner_u.push(2, w[i]);
        rd(codec_slot_pkg::OFF_STATUS, 32'h3);
        wr(codec_slot_pkg::OFF_STATUS, 32'h2);
        rd(codec_slot_pkg::OFF_STATUS, 32'h1);
        wr(codec_slot_pkg::OFF_STATUS, 32'h1);
        for (int i = 0; i < 4; i++) rd(codec_slot_pkg::OFF_FRONT_RIGHT, {12'h0, w[i]});
        // Pushes while receive is disabled are ignored
        wr(codec_slot_pkg::OFF_CTRL, 32'h0);
        for (int i = 0; i < 2; i++) partner_u.push(3, w[i]);
        rd(codec_slot_pkg::OFF_STATUS, 32'h0);
        rd(codec_slot_pkg::OFF_LINE_ONE, 32'h0);
        rd(codec_slot_pkg::OFF_LEFT_SURR, 32'h0);
        rd(codec_slot_pkg::OFF_RIGHT_SURR, 32'h0);
        rd(8'h7C, 32'h0);
        repeat (3) @(posedge clk);
        close_out();
    end
endmodule : testbench
